// >>> hw/mis_decimal_adjust.sv
// decimal adjust of the accumulator after addition
`timescale 1ns/1ps
module mis_decimal_adjust (
  // operands
  input  wire logic [7:0] acc,
  input  wire logic       half_carry_flag,
  input  wire logic       carry_in,
  // result
  output logic      [7:0] result,
  output logic            carry_out
);

  logic       nibble_carry_internal;
  logic [4:0] low_sum;
  logic [4:0] high_base;
  logic [4:0] high_sum;

  always_comb begin
    low_sum               = {1'b0, acc[3:0]};
    nibble_carry_internal = 1'b0;
    if ((acc[3:0] > mis_pkg::BCD_LIMIT) || half_carry_flag) begin
      low_sum               = {1'b0, acc[3:0]} + {1'b0, mis_pkg::BCD_ADJUST};
      nibble_carry_internal = low_sum[4];
    end
    high_base = {1'b0, acc[7:4]} + {4'h0, nibble_carry_internal};
    high_sum  = high_base;
    carry_out = carry_in;
    if ((high_base > {1'b0, mis_pkg::BCD_LIMIT}) || carry_in) begin
      high_sum  = high_base + {1'b0, mis_pkg::BCD_ADJUST};
      carry_out = 1'b1;
    end
    result = {high_sum[3:0], low_sum[3:0]};
  end

endmodule : mis_decimal_adjust

// >>> hw/mis_exec.sv
// execution unit for the watchdog, power-down, arithmetic, logic, move, branch and return operations
`timescale 1ns/1ps
// Summary of operation
// - watchdog and both flags clear only after both pre-clear operations ran
// - a lone pre-clear just records itself; watchdog and flags stay
// - invert memory writes the complemented byte back, zero flag only
// - invert to accumulator loads complement, zero flag, memory untouched
// - low nibble above 9 or half carry adds 6, nibble carry only when above 9
// - high nibble plus carry above 9 or carry adds 6, sets carry
// - decimal adjust writes memory byte; only carry flag may change
// - minus one reduces byte, zero flag; accumulator variant spares memory
// - plus one raises byte, zero flag; accumulator variant spares memory
// - power down stops execution, gates clock, keeps memory and registers
// - power down clears watchdog and prescaler, sets power flag, clears timeout
// - direct branch loads program counter from instruction, flags untouched
// - immediate load puts constant in accumulator; copies change no flags
// - idle operation only advances program counter, no flags change
// - disjunction into accumulator from memory or constant, zero flag only
// - disjunction to memory stores result in byte, zero flag only
// - subroutine exit restores counter from stack, two cycles, no flags
// - exit with constant restores counter and loads constant to accumulator
// - interrupt exit restores counter and sets global interrupt enable
// - rotate left in memory moves bit 7 into bit 0, no flags
// - rotate left to accumulator, memory and flags unchanged
// - writing the program counter low byte adds one extra cycle
module mis_exec (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // instruction from fetch path
  input  wire logic               instr_valid,
  input  wire mis_pkg::mis_instr_t instr,
  input  wire logic [12:0]        stack_top,
  // data memory read
  input  wire logic [7:0]         mem_rdata,
  // wake-up and watchdog events
  input  wire logic               wake_up,
  input  wire logic               wdt_overflow,
  // data memory write
  output logic                    mem_we,
  output logic [7:0]              mem_waddr,
  output logic [7:0]              mem_wdata,
  // core state
  output logic [12:0]             pc,
  output logic [7:0]              acc,
  output mis_pkg::mis_flags_t     flags,
  output logic                    global_irq_enable,
  output logic                    stack_pop,
  // power and timing
  output logic                    instr_ready,
  output logic                    sys_clk_enable,
  output logic                    halted,
  output logic                    wdt_clear,
  output logic                    prescaler_clear,
  output logic                    preclear_first_seen,
  output logic                    preclear_second_seen
);

  typedef enum logic [1:0] {MIS_RUN, MIS_EXTRA, MIS_SLEEP} mis_phase_t;

  typedef struct packed {
    logic                rst_meta;
    logic                rst_sync;
    mis_phase_t          mode;
    logic [1:0]          clk_count;
    logic [12:0]         pc;
    logic [7:0]          acc;
    mis_pkg::mis_flags_t flags;
    logic                irq_en;
    logic                seen_first;
    logic                seen_second;
    logic                mem_we;
    logic [7:0]          mem_waddr;
    logic [7:0]          mem_wdata;
    logic                stack_pop;
    logic                wdt_clear;
    logic                pre_clear;
  } mis_state_t;

  mis_state_t st;
  mis_state_t next_st;
  logic       rst_meta_q;
  logic       rst_sync_q;
  logic [7:0] daa_result;
  logic       daa_carry;

  //////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  mis_decimal_adjust u_daa (
    .acc             (st.acc),
    .half_carry_flag (st.flags.half_carry_flag),
    .carry_in        (st.flags.carry),
    .result          (daa_result),
    .carry_out       (daa_carry)
  );

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic       cycle_end;
    logic       acc_wr;
    logic [7:0] acc_val;
    logic       mem_wr;
    logic [7:0] mem_val;
    logic       pc_load;
    logic       extra;
    cycle_end  = (st.clk_count == mis_pkg::PHASE_LAST);
    acc_wr     = 1'b0;
    acc_val    = st.acc;
    mem_wr     = 1'b0;
    mem_val    = mem_rdata;
    pc_load    = 1'b0;
    extra      = 1'b0;
    next_st    = st;
    next_st.rst_meta  = 1'b0;
    next_st.rst_sync  = 1'b0;
    next_st.mem_we    = 1'b0;
    next_st.stack_pop = 1'b0;
    next_st.wdt_clear = 1'b0;
    next_st.pre_clear = 1'b0;
    if (wdt_overflow) begin
      next_st.flags.watchdog_timeout_flag = 1'b1;
    end
    case (st.mode)
      MIS_RUN: begin
        next_st.clk_count = st.clk_count + 2'h1;
        if (cycle_end && instr_valid) begin
          next_st.pc = st.pc + 13'h0001;
          case (instr.op)
            mis_pkg::MIS_PRECLEAR_FIRST, mis_pkg::MIS_PRECLEAR_SECOND: begin
              if ((instr.op == mis_pkg::MIS_PRECLEAR_FIRST && st.seen_second) ||
                  (instr.op == mis_pkg::MIS_PRECLEAR_SECOND && st.seen_first)) begin
                next_st.wdt_clear                   = 1'b1;
                next_st.flags.watchdog_timeout_flag = 1'b0;
                next_st.flags.power_down_flag       = 1'b0;
                next_st.seen_first                  = 1'b0;
                next_st.seen_second                 = 1'b0;
              end else if (instr.op == mis_pkg::MIS_PRECLEAR_FIRST) begin
                next_st.seen_first = 1'b1;
              end else begin
                next_st.seen_second = 1'b1;
              end
            end
            mis_pkg::MIS_INVERT_MEMORY: begin
              mem_wr  = 1'b1;
              mem_val = ~mem_rdata;
              next_st.flags.zero = is_zero(~mem_rdata);
            end
            mis_pkg::MIS_INVERT_TO_ACC: begin
              acc_wr  = 1'b1;
              acc_val = ~mem_rdata;
              next_st.flags.zero = is_zero(~mem_rdata);
            end
            mis_pkg::MIS_DECIMAL_ADJUST: begin
              mem_wr  = 1'b1;
              mem_val = daa_result;
              next_st.flags.carry = daa_carry;
            end
            mis_pkg::MIS_MINUS_ONE_MEM, mis_pkg::MIS_MINUS_ONE_ACC: begin
              mem_val = mem_rdata - 8'h01;
              acc_val = mem_val;
              mem_wr  = (instr.op == mis_pkg::MIS_MINUS_ONE_MEM);
              acc_wr  = !mem_wr;
              next_st.flags.zero = is_zero(mem_val);
            end
            mis_pkg::MIS_PLUS_ONE_MEM, mis_pkg::MIS_PLUS_ONE_ACC: begin
              mem_val = mem_rdata + 8'h01;
              acc_val = mem_val;
              mem_wr  = (instr.op == mis_pkg::MIS_PLUS_ONE_MEM);
              acc_wr  = !mem_wr;
              next_st.flags.zero = is_zero(mem_val);
            end
            mis_pkg::MIS_POWER_DOWN: begin
              next_st.mode                        = MIS_SLEEP;
              next_st.wdt_clear                   = 1'b1;
              next_st.pre_clear                   = 1'b1;
              next_st.flags.power_down_flag       = 1'b1;
              next_st.flags.watchdog_timeout_flag = 1'b0;
            end
            mis_pkg::MIS_DIRECT_BRANCH: begin
              next_st.pc = instr.target;
              pc_load    = 1'b1;
            end
            mis_pkg::MIS_COPY_MEM_TO_ACC: begin
              acc_wr  = 1'b1;
              acc_val = mem_rdata;
            end
            mis_pkg::MIS_COPY_IMM_TO_ACC: begin
              acc_wr  = 1'b1;
              acc_val = instr.imm;
            end
            mis_pkg::MIS_COPY_ACC_TO_MEM: begin
              mem_wr  = 1'b1;
              mem_val = st.acc;
            end
            mis_pkg::MIS_OR_MEM, mis_pkg::MIS_OR_IMM: begin
              acc_wr  = 1'b1;
              acc_val = st.acc | ((instr.op == mis_pkg::MIS_OR_IMM) ? instr.imm : mem_rdata);
              next_st.flags.zero = is_zero(acc_val);
            end
            mis_pkg::MIS_DISJUNCTION_TO_MEM: begin
              mem_wr  = 1'b1;
              mem_val = st.acc | mem_rdata;
              next_st.flags.zero = is_zero(mem_val);
            end
            mis_pkg::MIS_SUBROUTINE_EXIT, mis_pkg::MIS_EXIT_WITH_CONST, mis_pkg::MIS_INTERRUPT_EXIT: begin
              next_st.pc        = stack_top;
              next_st.stack_pop = 1'b1;
              pc_load           = 1'b1;
              if (instr.op == mis_pkg::MIS_EXIT_WITH_CONST) begin
                acc_wr  = 1'b1;
                acc_val = instr.imm;
              end
              if (instr.op == mis_pkg::MIS_INTERRUPT_EXIT) begin
                next_st.irq_en = 1'b1;
              end
            end
            mis_pkg::MIS_ROTATE_LEFT_MEM: begin
              mem_wr  = 1'b1;
              mem_val = {mem_rdata[6:0], mem_rdata[7]};
            end
            mis_pkg::MIS_ROTATE_LEFT_ACC: begin
              acc_wr  = 1'b1;
              acc_val = {mem_rdata[6:0], mem_rdata[7]};
            end
            default: begin
              // idle operation: counter advance only
            end
          endcase
          // low byte of the counter written through memory
          if (mem_wr && instr.mem_addr[3:0] == mis_pkg::PCL_ADDR && instr.mem_addr[7:4] == 4'h0) begin
            extra = 1'b1;
          end
          if (pc_load || extra) begin
            next_st.mode = MIS_EXTRA;
          end
          if (acc_wr) begin
            next_st.acc = acc_val;
          end
          next_st.mem_we    = mem_wr;
          next_st.mem_waddr = instr.mem_addr;
          next_st.mem_wdata = mem_val;
        end
      end
      MIS_EXTRA: begin
        next_st.clk_count = st.clk_count + 2'h1;
        if (cycle_end) begin
          next_st.mode = MIS_RUN;
        end
      end
      default: begin
        next_st.clk_count = 2'h0;
        if (wake_up) begin
          next_st.mode = MIS_RUN;
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      st           <= '0;
      st.mode      <= MIS_RUN;
      st.pc        <= mis_pkg::PC_RESET;
      st.acc       <= mis_pkg::ACC_RESET;
      st.flags     <= mis_pkg::FLAGS_RESET;
      st.mem_wdata <= mis_pkg::WDT_CLEAR;
    end else begin
      st <= next_st;
    end
  end

  assign mem_we               = st.mem_we;
  assign mem_waddr            = st.mem_waddr;
  assign mem_wdata            = st.mem_wdata;
  assign pc                   = st.pc;
  assign acc                  = st.acc;
  assign flags                = st.flags;
  assign global_irq_enable    = st.irq_en;
  assign stack_pop            = st.stack_pop;
  assign instr_ready          = (st.mode == MIS_RUN);
  assign sys_clk_enable       = (st.mode != MIS_SLEEP);
  assign halted               = (st.mode == MIS_SLEEP);
  assign wdt_clear            = st.wdt_clear;
  assign prescaler_clear      = st.pre_clear;
  assign preclear_first_seen  = st.seen_first;
  assign preclear_second_seen = st.seen_second;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_preclear_pair: assert property (@(posedge clk) disable iff (!rst_sync_q)
    $rose(st.wdt_clear) && !$past(st.mode == MIS_RUN && instr.op == mis_pkg::MIS_POWER_DOWN)
      |-> !st.flags.power_down_flag && !st.seen_first && !st.seen_second)
    else $error("watchdog clear without flag clear");
  a_lone_record: assert property (@(posedge clk) disable iff (!rst_sync_q)
    $rose(st.seen_first) |-> !st.wdt_clear && $stable(st.flags.power_down_flag))
    else $error("lone pre-clear changed state");
  a_record_holds: assert property (@(posedge clk) disable iff (!rst_sync_q)
    st.seen_first && !st.wdt_clear ##1 !st.wdt_clear |-> st.seen_first)
    else $error("pre-clear record lost");
  a_sleep_entry: assert property (@(posedge clk) disable iff (!rst_sync_q)
    $rose(st.mode == MIS_SLEEP) |-> st.wdt_clear && st.pre_clear && st.flags.power_down_flag
      && !st.flags.watchdog_timeout_flag)
    else $error("power down entry wrong");
  a_sleep_stalls: assert property (@(posedge clk) disable iff (!rst_sync_q)
    st.mode == MIS_SLEEP && !wake_up |=> $stable(st.pc) && $stable(st.acc) && !sys_clk_enable)
    else $error("state moved while asleep");
  a_exit_pops: assert property (@(posedge clk) disable iff (!rst_sync_q)
    st.stack_pop |-> st.mode == MIS_EXTRA ##1 (st.mode == MIS_EXTRA) [*3])
    else $error("exit not two cycles");
  a_extra_len: assert property (@(posedge clk) disable iff (!rst_sync_q)
    $rose(st.mode == MIS_EXTRA) |-> (st.mode == MIS_EXTRA) [*4] ##1 st.mode == MIS_RUN)
    else $error("extra cycle length wrong");
  a_mem_write_one: assert property (@(posedge clk) disable iff (!rst_sync_q)
    st.mem_we |=> !st.mem_we)
    else $error("memory write longer than a pulse");

endmodule : mis_exec

// >>> hw/mis_pkg.sv
// package: operation codes, flag layout, reset values and timing counts for the execution unit
package mis_pkg;

  localparam int DATA_W = 8;
  localparam int PC_W   = 13;
  localparam int WDT_W  = 8;
  localparam int PRE_W  = 8;

  // one instruction cycle of four system clocks
  localparam int           CLKS_PER_CYCLE = 4;
  localparam logic [1:0]   PHASE_LAST     = 2'h3;
  localparam logic [7:0]   WDT_CLEAR      = 8'h00;
  localparam logic [7:0]   PRE_CLEAR      = 8'h00;
  localparam logic [12:0]  PC_RESET       = 13'h0000;
  localparam logic [7:0]   ACC_RESET      = 8'h00;
  localparam logic [3:0]   BCD_LIMIT      = 4'h9;
  localparam logic [3:0]   BCD_ADJUST     = 4'h6;
  localparam logic [3:0]   PCL_ADDR       = 4'h6;

  typedef enum logic [4:0] {
    MIS_IDLE_OP,
    MIS_PRECLEAR_FIRST,
    MIS_PRECLEAR_SECOND,
    MIS_INVERT_MEMORY,
    MIS_INVERT_TO_ACC,
    MIS_DECIMAL_ADJUST,
    MIS_MINUS_ONE_MEM,
    MIS_MINUS_ONE_ACC,
    MIS_PLUS_ONE_MEM,
    MIS_PLUS_ONE_ACC,
    MIS_POWER_DOWN,
    MIS_DIRECT_BRANCH,
    MIS_COPY_MEM_TO_ACC,
    MIS_COPY_IMM_TO_ACC,
    MIS_COPY_ACC_TO_MEM,
    MIS_OR_MEM,
    MIS_OR_IMM,
    MIS_DISJUNCTION_TO_MEM,
    MIS_SUBROUTINE_EXIT,
    MIS_EXIT_WITH_CONST,
    MIS_INTERRUPT_EXIT,
    MIS_ROTATE_LEFT_MEM,
    MIS_ROTATE_LEFT_ACC
  } mis_op_t;

  // decoded instruction handed in by the fetch path
  typedef struct packed {
    mis_op_t     op;
    logic [7:0]  mem_addr;
    logic [7:0]  imm;
    logic [12:0] target;
  } mis_instr_t;

  typedef struct packed {
    logic watchdog_timeout_flag;
    logic power_down_flag;
    logic zero;
    logic carry;
    logic half_carry_flag;
  } mis_flags_t;

  localparam mis_flags_t FLAGS_RESET = '{default: 1'b0};

endpackage : mis_pkg

// >>> test/mis_exec_bench.sv
// self-checking bench for the execution unit
`timescale 1ns/1ps
module mis_exec_bench;
  logic                clk;
  logic                rst_n;
  logic                instr_valid;
  mis_pkg::mis_instr_t instr;
  logic [12:0]         stack_top;
  logic [7:0]          mem_rdata;
  logic                wake_up;
  logic                wdt_overflow;
  logic                mem_we;
  logic [7:0]          mem_waddr;
  logic [7:0]          mem_wdata;
  logic [12:0]         pc;
  logic [7:0]          acc;
  mis_pkg::mis_flags_t flags;
  logic                gie;
  logic                stack_pop;
  logic                instr_ready;
  logic                clk_en;
  logic                halted;
  logic                wdt_clear;
  logic                pre_clear;
  logic                seen1;
  logic                seen2;
  int                  err_total;
  int                  num_checks;
  int                  cycles;
  int                  wclr;
  int                  pclr;
  int                  pops;
  logic [7:0]          shadow [256];
  logic [7:0]          acc_e;
  logic [12:0]         pc_e;
  logic                gie_e;
  logic                f1;
  logic                f2;
  mis_pkg::mis_flags_t fl_e;

  mis_exec i_mis_exec (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .stack_top(stack_top), .mem_rdata(mem_rdata), .wake_up(wake_up), .wdt_overflow(wdt_overflow),
    .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .pc(pc), .acc(acc), .flags(flags),
    .global_irq_enable(gie), .stack_pop(stack_pop), .instr_ready(instr_ready), .sys_clk_enable(clk_en),
    .halted(halted), .wdt_clear(wdt_clear), .prescaler_clear(pre_clear),
    .preclear_first_seen(seen1), .preclear_second_seen(seen2));

  mis_mem_model i_mis_mem_model (.clk(clk), .raddr(instr.mem_addr), .rdata(mem_rdata),
    .we(mem_we), .waddr(mem_waddr), .wdata(mem_wdata));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    wclr   <= wclr + ((wdt_clear === 1'b1) ? 1 : 0);
    pclr   <= pclr + ((pre_clear === 1'b1) ? 1 : 0);
    pops   <= pops + ((stack_pop === 1'b1) ? 1 : 0);
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // one operation held for a full cycle, then a spare cycle for the extra-cycle ones
  task automatic issue(input mis_pkg::mis_op_t op, input logic [7:0] a, input logic [7:0] x, input logic [12:0] t);
    instr_valid = 1'b1;
    instr = '{op: op, mem_addr: a, imm: x, target: t};
    repeat (4) @(negedge clk);
    instr_valid = 1'b0;
    repeat (4) @(negedge clk);
  endtask : issue

  function automatic logic [8:0] bcd_fix(input logic [7:0] a, input logic c, input logic h);
    logic [4:0] lo;
    logic [4:0] hi;
    logic       nc;
    lo = {1'b0, a[3:0]};
    nc = 1'b0;
    if (lo > 5'h09 || h) begin
      lo = lo + 5'h06;
      nc = lo[4];
    end
    hi = {1'b0, a[7:4]} + {4'h0, nc};
    if (hi > 5'h09 || c) begin
      hi = hi + 5'h06;
      c = 1'b1;
    end
    return {c, hi[3:0], lo[3:0]};
  endfunction : bcd_fix

  task automatic compare_state(input logic [7:0] a);
    check("pc", 16'(pc), 16'(pc_e));
    check("acc", 16'(acc), 16'(acc_e));
    check("flags", 16'(flags), 16'(fl_e));
    check("irq_en", 16'(gie), 16'(gie_e));
    check("mem", 16'(i_mis_mem_model.mem[a]), 16'(shadow[a]));
  endtask : compare_state

  task automatic run_op(input mis_pkg::mis_op_t op, input logic [7:0] a, input logic [7:0] x, input logic [12:0] t);
    logic [7:0] m;
    logic [8:0] d;
    int         p;
    m = shadow[a];
    p = pops;
    d = bcd_fix(acc_e, fl_e.carry, fl_e.half_carry_flag);
    stack_top = 13'($urandom);
    pc_e = pc_e + 13'h0001;
    case (op)
      mis_pkg::MIS_INVERT_MEMORY:      shadow[a] = ~m;
      mis_pkg::MIS_INVERT_TO_ACC:      acc_e = ~m;
      mis_pkg::MIS_DECIMAL_ADJUST:     {fl_e.carry, shadow[a]} = d;
      mis_pkg::MIS_MINUS_ONE_MEM:      shadow[a] = m - 8'h01;
      mis_pkg::MIS_MINUS_ONE_ACC:      acc_e = m - 8'h01;
      mis_pkg::MIS_PLUS_ONE_MEM:       shadow[a] = m + 8'h01;
      mis_pkg::MIS_PLUS_ONE_ACC:       acc_e = m + 8'h01;
      mis_pkg::MIS_DIRECT_BRANCH:      pc_e = t;
      mis_pkg::MIS_COPY_MEM_TO_ACC:    acc_e = m;
      mis_pkg::MIS_COPY_IMM_TO_ACC:    acc_e = x;
      mis_pkg::MIS_COPY_ACC_TO_MEM:    shadow[a] = acc_e;
      mis_pkg::MIS_OR_MEM:             acc_e = acc_e | m;
      mis_pkg::MIS_OR_IMM:             acc_e = acc_e | x;
      mis_pkg::MIS_DISJUNCTION_TO_MEM: shadow[a] = acc_e | m;
      mis_pkg::MIS_SUBROUTINE_EXIT:    pc_e = stack_top;
      mis_pkg::MIS_EXIT_WITH_CONST:    {pc_e, acc_e} = {stack_top, x};
      mis_pkg::MIS_INTERRUPT_EXIT:     {pc_e, gie_e} = {stack_top, 1'b1};
      mis_pkg::MIS_ROTATE_LEFT_MEM:    shadow[a] = {m[6:0], m[7]};
      mis_pkg::MIS_ROTATE_LEFT_ACC:    acc_e = {m[6:0], m[7]};
      default: ;
    endcase
    if (op inside {mis_pkg::MIS_INVERT_MEMORY, mis_pkg::MIS_MINUS_ONE_MEM, mis_pkg::MIS_PLUS_ONE_MEM,
                   mis_pkg::MIS_DISJUNCTION_TO_MEM}) begin
      fl_e.zero = (shadow[a] == 8'h00);
    end
    if (op inside {mis_pkg::MIS_INVERT_TO_ACC, mis_pkg::MIS_MINUS_ONE_ACC, mis_pkg::MIS_PLUS_ONE_ACC,
                   mis_pkg::MIS_OR_MEM, mis_pkg::MIS_OR_IMM}) begin
      fl_e.zero = (acc_e == 8'h00);
    end
    issue(op, a, x, t);
    check("stack_pop", 16'(pops - p),
          16'(op inside {mis_pkg::MIS_SUBROUTINE_EXIT, mis_pkg::MIS_EXIT_WITH_CONST,
                         mis_pkg::MIS_INTERRUPT_EXIT}));
    compare_state(a);
  endtask : run_op

  task automatic preclear(input mis_pkg::mis_op_t op);
    int  n;
    logic both;
    n = wclr;
    both = (op == mis_pkg::MIS_PRECLEAR_FIRST) ? f2 : f1;
    pc_e = pc_e + 13'h0001;
    if (both) begin
      {fl_e.watchdog_timeout_flag, fl_e.power_down_flag, f1, f2} = 4'h0;
    end else begin
      f1 = f1 | (op == mis_pkg::MIS_PRECLEAR_FIRST);
      f2 = f2 | (op == mis_pkg::MIS_PRECLEAR_SECOND);
    end
    issue(op, 8'h00, 8'h00, 13'h0000);
    check("wdt_clear", 16'(wclr - n), {15'h0000, both});
    check("seen", 16'({seen1, seen2}), 16'({f1, f2}));
    compare_state(8'h00);
  endtask : preclear

  initial begin
    int               k;
    int               n;
    logic [7:0]       a;
    mis_pkg::mis_op_t op;
    k = $urandom(32'h431f);
    {rst_n, instr_valid, instr, stack_top, wake_up, wdt_overflow} = '0;
    for (k = 0; k < 256; k++) begin
      shadow[k] = 8'($urandom);
      i_mis_mem_model.mem[k] = shadow[k];
    end
    {acc_e, pc_e, fl_e, gie_e, f1, f2} = {mis_pkg::ACC_RESET, mis_pkg::PC_RESET, mis_pkg::FLAGS_RESET, 3'h0};
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    compare_state(8'h00);
    // decimal adjust corners, then every operation except the two pre-clears and power down once, then random traffic
    run_op(mis_pkg::MIS_COPY_IMM_TO_ACC, 8'h10, 8'h9a, 13'h0000);
    run_op(mis_pkg::MIS_DECIMAL_ADJUST, 8'h10, 8'h00, 13'h0000);
    run_op(mis_pkg::MIS_COPY_IMM_TO_ACC, 8'h11, 8'h45, 13'h0000);
    run_op(mis_pkg::MIS_DECIMAL_ADJUST, 8'h11, 8'h00, 13'h0000);
    run_op(mis_pkg::MIS_COPY_IMM_TO_ACC, 8'h20, 8'hff, 13'h0000);
    run_op(mis_pkg::MIS_COPY_ACC_TO_MEM, 8'h20, 8'h00, 13'h0000);
    run_op(mis_pkg::MIS_PLUS_ONE_MEM, 8'h20, 8'h00, 13'h0000);
    run_op(mis_pkg::MIS_MINUS_ONE_ACC, 8'h20, 8'h00, 13'h0000);
    run_op(mis_pkg::MIS_COPY_ACC_TO_MEM, 8'h06, 8'h00, 13'h0000);
    for (k = 0; k < 250; k++) begin
      op = mis_pkg::mis_op_t'((k < 23) ? k : $urandom_range(0, 22));
      if (op inside {mis_pkg::MIS_PRECLEAR_FIRST, mis_pkg::MIS_PRECLEAR_SECOND, mis_pkg::MIS_POWER_DOWN}) begin
        op = mis_pkg::MIS_IDLE_OP;
      end
      a = 8'($urandom);
      a = (a == mis_pkg::PCL_ADDR) ? 8'h07 : a;
      run_op(op, a, 8'($urandom), 13'($urandom));
    end
    // watchdog pre-clear pairing
    wdt_overflow = 1'b1;
    @(negedge clk);
    wdt_overflow = 1'b0;
    fl_e.watchdog_timeout_flag = 1'b1;
    preclear(mis_pkg::MIS_PRECLEAR_FIRST);
    preclear(mis_pkg::MIS_PRECLEAR_FIRST);
    preclear(mis_pkg::MIS_PRECLEAR_SECOND);
    // power down and wake
    n = pclr;
    k = wclr;
    pc_e = pc_e + 13'h0001;
    fl_e.power_down_flag = 1'b1;
    issue(mis_pkg::MIS_POWER_DOWN, 8'h00, 8'h00, 13'h0000);
    repeat (20) @(negedge clk);
    check("halted", 16'({halted, clk_en, instr_ready}), 16'h0004);
    check("wdt_pre_clear", 16'({8'(wclr - k), 8'(pclr - n)}), 16'h0101);
    compare_state(8'h00);
    wake_up = 1'b1;
    for (k = 0; k < 100 && instr_ready !== 1'b1; k++) begin
      @(negedge clk);
    end
    wake_up = 1'b0;
    check("ready", 16'(instr_ready), 16'h0001);
    compare_state(8'h20);
    preclear(mis_pkg::MIS_PRECLEAR_SECOND);
    preclear(mis_pkg::MIS_PRECLEAR_FIRST);
    close_out();
  end
endmodule : mis_exec_bench

// >>> test/mis_mem_model.sv
// data memory model facing the execution unit
`timescale 1ns/1ps
module mis_mem_model (
  // clock
  input  wire logic       clk,
  // read side
  input  wire logic [7:0] raddr,
  output logic      [7:0] rdata,
  // write side
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata
);
  logic [7:0] mem [256];

  assign rdata = mem[raddr];

  always @(posedge clk) begin
    if (we === 1'b1) begin
      mem[waddr] <= wdata;
    end
  end
endmodule : mis_mem_model
